//--- inc/dac_link_pkg.sv
package dac_link_pkg;

    // ==========================================================
    // clock and link timing
    // ==========================================================
    localparam int CLK_NS = 20;
    // serial clock half period; 80 ns period keeps well under the 30 MHz limit
    localparam int SCLK_HALF_NS = 40;
    // frame low to first falling clock edge
    localparam int SYNC_SETUP_NS = 20;
    // last falling clock edge to frame high
    localparam int SYNC_HOLD_NS = 20;
    // frame high time between words
    localparam int SYNC_HIGH_NS = 60;
    // pause between the two bytes of a byte-wide transfer
    localparam int BYTE_GAP_NS = 80;
    // decoder address settle time with the decoder disabled
    localparam int ADDR_SETTLE_NS = 20;

    // least times, rounded up to whole cycles
    localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SYNC_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (SYNC_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DESEL_CYC = (SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = (BYTE_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_CYC = (ADDR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W = 8;

    // ==========================================================
    // word layout
    // ==========================================================
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int DATA_W = 12;
    localparam int DEV_W = 2;
    localparam int NUM_DEV = 4;
    localparam int CHAN_HI_POS = 15;
    localparam int CHAN_LO_POS = 14;
    localparam int POWER_DOWN_N_POS = 13;
    localparam int LOAD_ALL_N_POS = 12;
    localparam int DATA_HI_POS = 11;
    localparam int LAST_BIT = 15;
    localparam int BYTE_LAST_BIT = 7;

    // ==========================================================
    // command buffer
    // ==========================================================
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = WORD_W + DEV_W;
    localparam int LEVEL_W = 5;
    localparam int COUNT_W = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_SETUP = 3'h3,
        ST_SHIFT = 3'h2,
        ST_GAP   = 3'h7,
        ST_HOLD  = 3'h6,
        ST_DESEL = 3'h4
    } link_state_e;

endpackage

//--- rtl/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr_r[AW-1:0]];
    assign level_o = wr_ptr_r - rd_ptr_r;

    always_ff @(posedge clk_i) begin
        if (ce_i && in_valid_i && !full) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
        end else if (ce_i && in_valid_i && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rd_ptr_r <= '0;
        end else if (ce_i && out_ready_i && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

endmodule

//--- rtl/dac_link_host.sv
`timescale 1ns/1ps
// Overview of operation
// - the host makes the serial clock itself, frames with an active-low select and sends 16-bit words.
// - the host changes each data bit on the rising clock edge and the device takes it on the next falling edge.
// - data stays stable and valid around every falling clock edge.
// - frame select goes low before the first data bit and stays low for the whole transfer.
// - in byte mode frame select stays low across both bytes and rises only after the second.
// - the word goes out most significant bit first.
// - an lsb-first shifter gets each byte bit-reversed beforehand so the device still sees msb first.
// - when the host clock shifts on its falling edge it is inverted toward the device.
// - with several devices on shared clock and data at most one frame select is low at a time.
// - the external decoder is disabled while its address inputs change.
// - bits 15:14 pick the channel, bit 13 is active-low power down, bit 12 active-low load all, the rest data.
module dac_link_host (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [1:0] cmd_dev_i,
    input wire logic [1:0] cmd_channel_i,
    input wire logic cmd_power_down_n_bit_i,
    input wire logic cmd_load_all_n_bit_i,
    input wire logic [11:0] cmd_data_i,
    input wire logic byte_mode_i,
    input wire logic lsb_first_i,
    input wire logic clk_invert_i,
    output logic sclk_o,
    output logic host_shift_clock_o,
    output logic din_o,
    output logic [3:0] sync_n_o,
    output logic [1:0] dec_addr_o,
    output logic dec_en_n_o,
    output logic busy_o,
    output logic [4:0] fifo_level_o,
    output logic [15:0] words_sent_o
);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [dac_link_pkg::WORD_W-1:0] build_word(
        input logic [1:0] chan,
        input logic pd_n,
        input logic ld_n,
        input logic [dac_link_pkg::DATA_W-1:0] data
    );
        logic [dac_link_pkg::WORD_W-1:0] w;
        w = '0;
        w[dac_link_pkg::CHAN_HI_POS] = chan[1];
        w[dac_link_pkg::CHAN_LO_POS] = chan[0];
        w[dac_link_pkg::POWER_DOWN_N_POS] = pd_n;
        // ld_n high stores one channel, low moves all four at word end
        w[dac_link_pkg::LOAD_ALL_N_POS] = ld_n;
        w[dac_link_pkg::DATA_HI_POS:0] = data;
        return w;
    endfunction

    function automatic logic [dac_link_pkg::BYTE_W-1:0] rev_byte(
        input logic [dac_link_pkg::BYTE_W-1:0] b
    );
        logic [dac_link_pkg::BYTE_W-1:0] r;
        r = '0;
        for (int i = 0; i < dac_link_pkg::BYTE_W; i++) begin
            r[i] = b[dac_link_pkg::BYTE_W-1-i];
        end
        return r;
    endfunction

    // bit sent at position idx; first byte is the upper one
    function automatic logic pick_bit(
        input logic [dac_link_pkg::WORD_W-1:0] w,
        input logic [3:0] idx,
        input logic lsb
    );
        logic [dac_link_pkg::BYTE_W-1:0] b;
        logic [2:0] k;
        b = idx[3] ? w[dac_link_pkg::BYTE_W-1:0] : w[dac_link_pkg::WORD_W-1:dac_link_pkg::BYTE_W];
        k = idx[2:0];
        return lsb ? b[k] : b[3'h7 - k];
    endfunction

    function automatic logic framed(input dac_link_pkg::link_state_e s);
        return (s == dac_link_pkg::ST_SETUP) || (s == dac_link_pkg::ST_SHIFT) ||
               (s == dac_link_pkg::ST_GAP) || (s == dac_link_pkg::ST_HOLD);
    endfunction

    localparam logic [7:0] HALF_LD = 8'(dac_link_pkg::HALF_CYC - 1);
    localparam logic [7:0] SETUP_LD = 8'(dac_link_pkg::SETUP_CYC - 1);
    localparam logic [7:0] HOLD_LD = 8'(dac_link_pkg::HOLD_CYC - 1);
    localparam logic [7:0] DESEL_LD = 8'(dac_link_pkg::DESEL_CYC - 1);
    localparam logic [7:0] GAP_LD = 8'(dac_link_pkg::GAP_CYC - 1);
    localparam logic [7:0] ADDR_LD = 8'(dac_link_pkg::ADDR_CYC - 1);
    localparam logic [4:0] LAST_FALL = 5'(dac_link_pkg::LAST_BIT);
    localparam logic [4:0] BYTE_FALL = 5'(dac_link_pkg::BYTE_LAST_BIT);
    localparam logic [4:0] FIFO_FULL = 5'(dac_link_pkg::FIFO_DEPTH);

    // ==========================================================
    // command buffer
    // ==========================================================
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [dac_link_pkg::FIFO_W-1:0] fifo_out_data;
    logic [4:0] fifo_level;
    logic [4:0] level_nxt;
    logic in_fire;
    logic out_fire;
    logic cmd_ready_r;
    logic [4:0] fifo_level_r;

    assign in_fire = cmd_valid_i && cmd_ready_r && fifo_in_ready;
    assign out_fire = fifo_out_valid && fifo_pop;
    assign level_nxt = fifo_level + {4'h0, in_fire} - {4'h0, out_fire};

    word_fifo #(
        .WIDTH(dac_link_pkg::FIFO_W),
        .DEPTH(dac_link_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .in_valid_i(cmd_valid_i && cmd_ready_r),
        .in_ready_o(fifo_in_ready),
        .in_data_i({cmd_dev_i, build_word(cmd_channel_i, cmd_power_down_n_bit_i,
                                          cmd_load_all_n_bit_i, cmd_data_i)}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data),
        .level_o(fifo_level)
    );

    // ready is registered from the level one step ahead, so it never overruns
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_ready_r <= 1'b0;
            fifo_level_r <= '0;
        end else if (ce_i) begin
            cmd_ready_r <= (level_nxt < FIFO_FULL);
            fifo_level_r <= level_nxt;
        end
    end

    // ==========================================================
    // link sequencer
    // ==========================================================
    dac_link_pkg::link_state_e state_r;
    dac_link_pkg::link_state_e state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [4:0] bit_r;
    logic [4:0] bit_nxt;
    logic sclk_r;
    logic sclk_nxt;
    logic din_r;
    logic din_nxt;
    logic [dac_link_pkg::WORD_W-1:0] word_r;
    logic [1:0] dev_r;
    logic lsb_r;
    logic byte_r;
    logic inv_r;

    // only pop while idle: a word is taken whole or not at all
    assign fifo_pop = (state_r == dac_link_pkg::ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
        bit_nxt = bit_r;
        sclk_nxt = sclk_r;
        din_nxt = din_r;
        unique case (state_r)
            dac_link_pkg::ST_IDLE: begin
                sclk_nxt = 1'b0;
                bit_nxt = '0;
                if (fifo_out_valid) begin
                    state_nxt = dac_link_pkg::ST_ADDR;
                    cnt_nxt = ADDR_LD;
                end
            end
            dac_link_pkg::ST_ADDR: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = dac_link_pkg::ST_SETUP;
                    cnt_nxt = SETUP_LD;
                end
            end
            dac_link_pkg::ST_SETUP: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = dac_link_pkg::ST_SHIFT;
                    cnt_nxt = HALF_LD;
                end
            end
            dac_link_pkg::ST_SHIFT: begin
                if (cnt_r == 8'h00) begin
                    cnt_nxt = HALF_LD;
                    if (!sclk_r) begin
                        // new bit with the rising edge, held over the falling one
                        sclk_nxt = 1'b1;
                        din_nxt = pick_bit(word_r, bit_r[3:0], lsb_r);
                    end else begin
                        sclk_nxt = 1'b0;
                        bit_nxt = bit_r + 5'h01;
                        if (bit_r == LAST_FALL) begin
                            // exactly sixteen falls; fewer would be dropped by the device
                            state_nxt = dac_link_pkg::ST_HOLD;
                            cnt_nxt = HOLD_LD;
                        end else if (byte_r && bit_r == BYTE_FALL) begin
                            state_nxt = dac_link_pkg::ST_GAP;
                            cnt_nxt = GAP_LD;
                        end
                    end
                end
            end
            dac_link_pkg::ST_GAP: begin
                // frame stays low between the two bytes
                if (cnt_r == 8'h00) begin
                    state_nxt = dac_link_pkg::ST_SHIFT;
                    cnt_nxt = HALF_LD;
                end
            end
            dac_link_pkg::ST_HOLD: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = dac_link_pkg::ST_DESEL;
                    cnt_nxt = DESEL_LD;
                    din_nxt = 1'b0;
                end
            end
            dac_link_pkg::ST_DESEL: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = dac_link_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = dac_link_pkg::ST_IDLE;
                cnt_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= dac_link_pkg::ST_IDLE;
            cnt_r <= 8'h00;
            bit_r <= '0;
            sclk_r <= 1'b0;
            din_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            sclk_r <= sclk_nxt;
            din_r <= din_nxt;
        end
    end

    // word and per-word options latched at pop; mid-frame changes wait
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            word_r <= '0;
            dev_r <= '0;
            lsb_r <= 1'b0;
            byte_r <= 1'b0;
            inv_r <= 1'b0;
        end else if (ce_i && out_fire) begin
            dev_r <= fifo_out_data[dac_link_pkg::FIFO_W-1:dac_link_pkg::WORD_W];
            lsb_r <= lsb_first_i;
            byte_r <= byte_mode_i;
            inv_r <= clk_invert_i;
            if (lsb_first_i) begin
                word_r <= {rev_byte(fifo_out_data[15:8]), rev_byte(fifo_out_data[7:0])};
            end else begin
                word_r <= fifo_out_data[dac_link_pkg::WORD_W-1:0];
            end
        end
    end

    // ==========================================================
    // pins
    // ==========================================================
    logic sclk_pin_r;
    logic host_clk_r;
    logic din_pin_r;
    logic [3:0] sync_n_r;
    logic [1:0] dec_addr_r;
    logic dec_en_n_r;

    // device pin keeps falling-edge capture; host clock is its inverse when shifting on fall
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sclk_pin_r <= 1'b0;
            host_clk_r <= 1'b0;
            din_pin_r <= 1'b0;
        end else if (ce_i) begin
            sclk_pin_r <= sclk_nxt;
            host_clk_r <= sclk_nxt ^ inv_r;
            din_pin_r <= din_nxt;
        end
    end

    // one select at most; decoder address moves only while its enable is off
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync_n_r <= 4'hf;
            dec_addr_r <= 2'h0;
            dec_en_n_r <= 1'b1;
        end else if (ce_i) begin
            for (int d = 0; d < dac_link_pkg::NUM_DEV; d++) begin
                sync_n_r[d] <= !(framed(state_nxt) && dev_r == 2'(d));
            end
            if (state_r == dac_link_pkg::ST_IDLE && out_fire) begin
                dec_addr_r <= fifo_out_data[dac_link_pkg::FIFO_W-1:dac_link_pkg::WORD_W];
            end
            dec_en_n_r <= !framed(state_nxt);
        end
    end

    // ==========================================================
    // status
    // ==========================================================
    logic busy_r;
    logic [15:0] words_sent_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            busy_r <= 1'b0;
            words_sent_r <= '0;
        end else if (ce_i) begin
            busy_r <= (state_nxt != dac_link_pkg::ST_IDLE) || (level_nxt != 5'h00);
            if (state_r == dac_link_pkg::ST_HOLD && state_nxt == dac_link_pkg::ST_DESEL) begin
                words_sent_r <= words_sent_r + 16'h0001;
            end
        end
    end

    assign cmd_ready_o = cmd_ready_r;
    assign fifo_level_o = fifo_level_r;
    assign sclk_o = sclk_pin_r;
    assign host_shift_clock_o = host_clk_r;
    assign din_o = din_pin_r;
    assign sync_n_o = sync_n_r;
    assign dec_addr_o = dec_addr_r;
    assign dec_en_n_o = dec_en_n_r;
    assign busy_o = busy_r;
    assign words_sent_o = words_sent_r;

endmodule

//--- verif/dac_link_host_sva.sv
`timescale 1ns/1ps
// ==========================================================
// link pin checker
// ==========================================================
module dac_link_host_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cmd_ready_o,
    input wire logic sclk_o,
    input wire logic host_shift_clock_o,
    input wire logic din_o,
    input wire logic [3:0] sync_n_o,
    input wire logic [1:0] dec_addr_o,
    input wire logic dec_en_n_o,
    input wire logic [4:0] fifo_level_o
);
    logic [4:0] falls_r;
    wire logic all_high = &sync_n_o;

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // falling clock edges seen inside the current frame
    always_ff @(posedge clk_i) begin
        if (reset_i || all_high) begin
            falls_r <= 5'h0;
        end else if ($fell(sclk_o)) begin
            falls_r <= falls_r + 5'h1;
        end
    end

    chk_one_select: assert property ($onehot0(~sync_n_o))
        else $error("more than one frame select low");
    chk_sel_addr: assert property (!dec_en_n_o |-> !sync_n_o[dec_addr_o])
        else $error("active select differs from decoder address");
    chk_dec_enable: assert property (dec_en_n_o == all_high)
        else $error("decoder enable disagrees with selects");
    chk_addr_settle: assert property ($changed(dec_addr_o) |-> dec_en_n_o && $past(dec_en_n_o))
        else $error("decoder address moved while enabled");
    chk_idle_clock: assert property (all_high |-> !sclk_o)
        else $error("serial clock high outside a frame");
    chk_data_stable: assert property ($fell(sclk_o) |-> $stable(din_o))
        else $error("data moved at a capture edge");
    chk_framed_clock: assert property ($changed(sclk_o) |-> !all_high && $past(!all_high))
        else $error("clock toggled outside the frame");
    chk_sixteen_falls: assert property ($rose(all_high) |-> falls_r == 5'h10)
        else $error("frame did not carry sixteen falling edges");
    chk_desel_gap: assert property ($rose(all_high) |-> all_high [*3])
        else $error("frame select high too briefly");
    chk_inv_steady: assert property (!all_high && $past(!all_high)
        |-> $stable(host_shift_clock_o ^ sclk_o))
        else $error("clock inversion changed inside a frame");
    chk_full_refuse: assert property (fifo_level_o == 5'h10 |-> !cmd_ready_o)
        else $error("ready while buffer full");
endmodule

bind dac_link_host dac_link_host_chk u_chk (.clk_i, .reset_i, .cmd_ready_o, .sclk_o,
    .host_shift_clock_o, .din_o, .sync_n_o, .dec_addr_o, .dec_en_n_o, .fifo_level_o);

//--- verif/dac_device_model.sv
`timescale 1ns/1ps
// ==========================================================
// quad converter model, write-only serial input
// ==========================================================
module dac_device_model (
    input wire logic sync_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic [15:0] word_o,
    output logic [15:0] count_o
);
    logic [15:0] shift_r;
    logic [4:0] bits_r = 5'h0;
    logic [11:0] input_r [4] = '{default: 12'h0};
    logic [11:0] output_r [4] = '{default: 12'h0};
    logic power_n_r = 1'b1;
    wire logic [15:0] next_word = {shift_r[14:0], din_i};

    initial begin
        word_o = 16'h0;
        count_o = 16'h0;
    end

    // a rising select re-arms the input; a partial word never lands
    always @(negedge sclk_i or posedge sync_n_i) begin
        if (sync_n_i) begin
            bits_r <= 5'h0;
        end else if (bits_r != 5'h10) begin
            shift_r <= next_word;
            bits_r <= bits_r + 5'h1;
            if (bits_r == 5'hf) begin
                word_o <= next_word;
                count_o <= count_o + 16'h1;
                power_n_r <= next_word[13];
                input_r[next_word[15:14]] <= next_word[11:0];
                if (!next_word[12]) begin
                    for (int c = 0; c < 4; c++) begin
                        output_r[c] <= (c == next_word[15:14]) ? next_word[11:0] : input_r[c];
                    end
                end
            end
        end
    end
endmodule

//--- verif/tb_dac_link_host.sv
`timescale 1ns/1ps
module tb_dac_link_host;
    logic clk_i, reset_i, ce_i, cmd_valid_i, byte_mode_i, lsb_first_i, clk_invert_i;
    logic [1:0] cmd_dev_i, cmd_channel_i;
    logic cmd_power_down_n_bit_i, cmd_load_all_n_bit_i;
    logic [11:0] cmd_data_i;
    logic cmd_ready_o, sclk_o, host_shift_clock_o, din_o, dec_en_n_o, busy_o;
    logic [3:0] sync_n_o;
    logic [1:0] dec_addr_o;
    logic [4:0] fifo_level_o;
    logic [15:0] words_sent_o;
    wire logic [15:0] dev_word [4];
    wire logic [15:0] dev_count [4];
    logic [15:0] seen [4] = '{default: 16'h0};
    logic [15:0] exp_q [4][$];
    int failures = 0, samples_checked = 0, cycles = 0, seed = 2, sent = 0;
    logic rand_on = 1'b0;
    logic inv_chk = 1'b1;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    dac_link_host u_dut (.clk_i, .reset_i, .ce_i, .cmd_valid_i, .cmd_ready_o, .cmd_dev_i,
        .cmd_channel_i, .cmd_power_down_n_bit_i, .cmd_load_all_n_bit_i, .cmd_data_i,
        .byte_mode_i, .lsb_first_i, .clk_invert_i, .sclk_o, .host_shift_clock_o, .din_o,
        .sync_n_o, .dec_addr_o, .dec_en_n_o, .busy_o, .fifo_level_o, .words_sent_o);

    for (genvar d = 0; d < 4; d++) begin : g_dev
        dac_device_model u_dev (.sync_n_i(sync_n_o[d]), .sclk_i(sclk_o), .din_i(din_o),
            .word_o(dev_word[d]), .count_o(dev_count[d]));
    end

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [15:0] mk_word(logic [1:0] ch, logic pd, logic ld, logic [11:0] v);
        return {ch, pd, ld, v};
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // valid stays up on return so commands can follow back to back
    task automatic send(input logic [1:0] dev, input logic [1:0] ch, input logic pd,
                        input logic ld, input logic [11:0] v);
        @(negedge clk_i);
        cmd_valid_i <= 1'b1;
        {cmd_dev_i, cmd_channel_i, cmd_power_down_n_bit_i, cmd_load_all_n_bit_i, cmd_data_i}
            <= {dev, ch, pd, ld, v};
        do @(posedge clk_i); while (!(ce_i === 1'b1 && cmd_ready_o === 1'b1));
        exp_q[dev].push_back(mk_word(ch, pd, ld, v));
        sent++;
    endtask

    task automatic pause(input int n);
        @(negedge clk_i);
        cmd_valid_i <= 1'b0;
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wait_idle();
        int n;
        pause(1);
        n = 0;
        while ((busy_o !== 1'b0 || sync_n_o !== 4'hf) && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 5000)
            failures++;
        repeat (4) @(negedge clk_i);
    endtask

    // ==========================================================
    // monitor, random pin noise and timeout
    // ==========================================================
    always @(negedge clk_i) begin
        cycles++;
        if (cycles > 40000) begin
            failures++;
            report_and_stop();
        end
        // modes stay put per word only until the random phase starts
        if (inv_chk && sync_n_o !== 4'hf)
            check("host clock", {15'h0, sclk_o ^ clk_invert_i}, {15'h0, host_shift_clock_o});
        for (int d = 0; d < 4; d++) begin
            if (dev_count[d] !== seen[d]) begin
                seen[d] = dev_count[d];
                check("device word", exp_q[d].size() ? exp_q[d].pop_front() : 16'hx, dev_word[d]);
            end
        end
    end

    // modes change freely: they are latched per word and never alter the wire image
    always @(negedge clk_i) begin
        if (rand_on) begin
            ce_i <= ($random(seed) & 3) != 0;
            {byte_mode_i, lsb_first_i, clk_invert_i} <= 3'($random(seed));
        end
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {cmd_valid_i, byte_mode_i, lsb_first_i, clk_invert_i} = 4'h0;
        {cmd_dev_i, cmd_channel_i, cmd_power_down_n_bit_i, cmd_load_all_n_bit_i} = 6'h0;
        cmd_data_i = 12'h0;
        ce_i = 1'b1;
        reset_i = 1'b1;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        check("idle selects", 16'h000f, {12'h0, sync_n_o});
        check("idle clock", 16'h0, {15'h0, sclk_o});
        // every mode combination, device and channel, one word at a time
        for (int i = 0; i < 8; i++) begin
            {byte_mode_i, lsb_first_i, clk_invert_i} <= 3'(i);
            send(2'(i), 2'(3 - i), i[1], i[2], i[0] ? 12'hfff : 12'h000);
            wait_idle();
        end
        // burst until the buffer refuses, then drain
        for (int i = 0; i < 20; i++) begin
            send(2'($random(seed)), 2'($random(seed)), 1'($random(seed)), 1'b1, 12'($random(seed)));
        end
        wait_idle();
        inv_chk = 1'b0;
        rand_on = 1'b1;
        for (int i = 0; i < 24; i++) begin
            send(2'($random(seed)), 2'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                 12'($random(seed)));
            if ($random(seed) & 1)
                pause(int'(3'($random(seed))));
        end
        rand_on = 1'b0;
        @(negedge clk_i);
        ce_i <= 1'b1;
        wait_idle();
        check("words sent", 16'(sent), words_sent_o);
        for (int d = 0; d < 4; d++) begin
            check("words pending", 16'h0, 16'(exp_q[d].size()));
        end
        report_and_stop();
    end
endmodule
